// ---- mrr_cfg.svh ----
/*
 Constants of the move / return / rotate execute block: widths, register
 offsets, field positions and reset values.
 Assumes it is included by bare name from the package and the design files.
*/
`ifndef MRR_CFG_SVH
`define MRR_CFG_SVH

// ----------------------------------------------------------------------
// Widths and depths
// ----------------------------------------------------------------------
`define MRR_PC_W 13
`define MRR_STK_D 8
`define MRR_STK_PW 3
`define MRR_FILE_D 128
`define MRR_PC_STEP 13'h0001
`define MRR_STK_STEP 3'h1

// ----------------------------------------------------------------------
// Bus map (byte addresses), file window at bit 9
// ----------------------------------------------------------------------
`define MRR_OFS_CTRL 10'h000
`define MRR_OFS_STATUS 10'h004
`define MRR_OFS_ACC 10'h008
`define MRR_OFS_PC 10'h00c
`define MRR_OFS_STACK 10'h010
`define MRR_FILE_BIT 9

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MRR_CTRL_RUN 0
`define MRR_ST_Z 0
`define MRR_ST_C 1
`define MRR_ST_GIE 2
`define MRR_ST_BUSY 3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define MRR_RST_RUN 1'b1
`define MRR_RST_ACC 8'h00
`define MRR_RST_PC 13'h0000
`define MRR_RST_FLAG 1'b0
`define MRR_RST_PTR 3'h0

`endif

// ---- mrr_pkg.sv ----
/*
 Types of the move / return / rotate execute block.
 Assumes mrr_cfg.svh is on the include path.
*/
`default_nettype none
`include "mrr_cfg.svh"

package mrr_pkg;
    // Opcodes handed over by decode
    typedef enum logic [2:0] {
        OP_IDLE = 3'h0,
        OP_COPY = 3'h1,
        OP_LOADK = 3'h2,
        OP_STORE = 3'h3,
        OP_RETI = 3'h4,
        OP_RETK = 3'h5,
        OP_RLC = 3'h6
    } mrr_op_e;

    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_RELOAD = 2'b10
    } mrr_state_e;

    typedef logic [`MRR_PC_W-1:0] mrr_pc_t;
endpackage

`default_nettype wire

// ---- mrr_result_unit.sv ----
/*
 Result path: selects the 8-bit value an instruction produces, the carry
 that follows from it and its zero test.
 Assumes operands are stable for the whole cycle; purely combinational.
*/
`default_nettype none
`include "mrr_cfg.svh"

module mrr_result_unit (
    input wire mrr_pkg::mrr_op_e op,
    input wire logic [7:0] src,
    input wire logic [7:0] acc,
    input wire logic [7:0] lit,
    input wire logic carry_in,
    output logic [7:0] res,
    output logic carry_out,
    output logic zero
);
    import mrr_pkg::*;

    wire logic [7:0] rotated;
    wire logic is_lit;

    // Old carry enters bit 0, bit 7 leaves into carry
    assign rotated = {src[6:0], carry_in}; // RL8
    assign is_lit = (op == OP_LOADK) || (op == OP_RETK);
    assign res = (op == OP_RLC) ? rotated :
                 (op == OP_COPY) ? src :
                 is_lit ? lit : acc; // RL3 RL6
    assign carry_out = (op == OP_RLC) ? src[7] : carry_in; // RL8
    assign zero = (res == 8'h00); // RL10
endmodule

`default_nettype wire

// ---- mrr_exec.sv ----
/*
 Execute stage for copy, literal load, accumulator store, idle, the two
 returns and rotate-left-through-carry, with accumulator, 128-byte file,
 zero/carry, program counter, return stack and interrupt enable, all
 reachable over a classic Wishbone slave.
 Assumes decode presents one instruction per cycle with a valid flag and
 holds it until taken; everything runs on clk_sys.
*/
// Chosen here: the register addresses and the Wishbone interface to the registers.
`default_nettype none
`include "mrr_cfg.svh"

// Functional notes
// [RL1] Copy moves file byte to accumulator (dest 0) or back to itself (dest 1).
// [RL2] Copy updates the zero flag from the moved value.
// [RL3] Literal load puts the literal in the accumulator, flags untouched.
// [RL4] Return from interrupt pops stack head into PC, sets interrupt enable.
// [RL5] Store writes accumulator into the addressed file byte, flags untouched.
// [RL6] Return with literal loads accumulator and pops stack head into PC.
// [RL7] Return with literal occupies two instruction cycles.
// [RL8] Rotate left through carry; only carry changes.
// [RL9] Rotate result goes to accumulator (dest 0) or source byte (dest 1).
// [RL10] Zero flag marks a zero result; idle only steps the PC in one cycle.
module mrr_exec (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic instr_valid,
    input wire mrr_pkg::mrr_op_e instr_op,
    input wire logic [6:0] instr_file,
    input wire logic instr_dest,
    input wire logic [7:0] instr_lit,
    output logic instr_ready,
    output mrr_pkg::mrr_pc_t pc_out,
    output logic [7:0] acc_out,
    output logic irq_enable
);
    import mrr_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [7:0] file_mem [`MRR_FILE_D];
    mrr_pc_t stk_mem [`MRR_STK_D];
    logic [`MRR_STK_PW-1:0] ptr_r, ptr_nxt;
    mrr_pc_t pc_r, pc_nxt;
    logic [7:0] acc_r, acc_nxt;
    logic z_r, z_nxt, c_r, c_nxt, gie_r, gie_nxt, run_r, run_nxt;
    logic ready_r, ready_nxt, ack_r;
    logic [31:0] dat_r;
    mrr_state_e st_r, st_nxt;

    // ------------------------------------------------------------------
    // Instruction decode
    // ------------------------------------------------------------------
    wire logic accept, dual, pop, acc_we, file_we, carry_up, zero_up;
    wire logic [7:0] src, res;
    wire logic res_c, res_z;
    wire mrr_pc_t stk_head;

    assign accept = instr_valid && ready_r;
    assign src = file_mem[instr_file];
    assign stk_head = stk_mem[ptr_r - `MRR_STK_STEP];
    assign dual = (instr_op == OP_COPY) || (instr_op == OP_RLC);
    assign pop = accept && ((instr_op == OP_RETI) || (instr_op == OP_RETK)); // RL4 RL6
    assign acc_we = accept && ((dual && !instr_dest) || (instr_op == OP_LOADK)
                               || (instr_op == OP_RETK)); // RL1 RL3 RL6 RL9
    assign file_we = accept && ((dual && instr_dest) || (instr_op == OP_STORE)); // RL5 RL9
    assign zero_up = accept && (instr_op == OP_COPY); // RL2
    assign carry_up = accept && (instr_op == OP_RLC); // RL8

    mrr_result_unit u_res (
        .op(instr_op),
        .src(src),
        .acc(acc_r),
        .lit(instr_lit),
        .carry_in(c_r),
        .res(res),
        .carry_out(res_c),
        .zero(res_z)
    );

    // ------------------------------------------------------------------
    // Bus decode; a write lands on the edge where ack is high
    // ------------------------------------------------------------------
    wire logic bus_req, bus_wr, hit_file, hit_ctrl, hit_st, hit_acc, hit_pc, hit_stk;
    wire logic [6:0] bus_idx;
    wire logic [3:0] st_val;
    wire logic [31:0] rd_val;

    assign bus_req = wb_cyc_i && wb_stb_i;
    assign bus_wr = bus_req && wb_we_i && ack_r;
    assign hit_file = wb_adr_i[`MRR_FILE_BIT];
    assign bus_idx = wb_adr_i[8:2];
    assign hit_ctrl = (wb_adr_i == `MRR_OFS_CTRL);
    assign hit_st = (wb_adr_i == `MRR_OFS_STATUS);
    assign hit_acc = (wb_adr_i == `MRR_OFS_ACC);
    assign hit_pc = (wb_adr_i == `MRR_OFS_PC);
    assign hit_stk = (wb_adr_i == `MRR_OFS_STACK);
    assign st_val[`MRR_ST_Z] = z_r;
    assign st_val[`MRR_ST_C] = c_r;
    assign st_val[`MRR_ST_GIE] = gie_r;
    assign st_val[`MRR_ST_BUSY] = (st_r == ST_RELOAD);
    // Unmapped addresses read zero and still answer
    assign rd_val = hit_file ? {24'h0, file_mem[bus_idx]} :
                    hit_ctrl ? {31'h0, run_r} :
                    hit_st ? {28'h0, st_val} :
                    hit_acc ? {24'h0, acc_r} :
                    hit_pc ? {19'h0, pc_r} :
                    hit_stk ? {19'h0, stk_head} : 32'h0;

    wire logic wr_lo, wr_hi, push;
    wire mrr_pc_t pc_bus;
    assign wr_lo = bus_wr && wb_sel_i[0];
    assign wr_hi = bus_wr && wb_sel_i[1];
    assign pc_bus = {wr_hi ? wb_dat_i[12:8] : pc_r[12:8], wr_lo ? wb_dat_i[7:0] : pc_r[7:0]};
    // A pop in the same cycle wins over a software push
    assign push = wr_lo && wr_hi && hit_stk && !pop;

    // ------------------------------------------------------------------
    // Next values: the instruction stream wins over software writes
    // ------------------------------------------------------------------
    assign acc_nxt = acc_we ? res : (wr_lo && hit_acc) ? wb_dat_i[7:0] : acc_r;
    assign pc_nxt = pop ? stk_head : // RL4 RL6
                    accept ? pc_r + `MRR_PC_STEP : // RL10
                    ((wr_lo || wr_hi) && hit_pc) ? pc_bus : pc_r;
    assign z_nxt = zero_up ? res_z : (wr_lo && hit_st) ? wb_dat_i[`MRR_ST_Z] : z_r; // RL2 RL10
    assign c_nxt = carry_up ? res_c : (wr_lo && hit_st) ? wb_dat_i[`MRR_ST_C] : c_r; // RL8
    assign gie_nxt = (accept && instr_op == OP_RETI) ? 1'b1 : // RL4
                     (wr_lo && hit_st) ? wb_dat_i[`MRR_ST_GIE] : gie_r;
    assign run_nxt = (wr_lo && hit_ctrl) ? wb_dat_i[`MRR_CTRL_RUN] : run_r;
    assign ptr_nxt = pop ? ptr_r - `MRR_STK_STEP : push ? ptr_r + `MRR_STK_STEP : ptr_r;

    // A pop costs one dead cycle while the reloaded PC refetches
    always_comb begin
        unique case (st_r)
            ST_RUN: st_nxt = (pop && instr_op == OP_RETK) ? ST_RELOAD :
                             pop ? ST_RELOAD : ST_RUN; // RL7
            ST_RELOAD: st_nxt = ST_RUN;
            default: st_nxt = ST_RUN;
        endcase
    end
    assign ready_nxt = run_nxt && (st_nxt == ST_RUN); // RL7

    // ------------------------------------------------------------------
    // Flip-flops
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            acc_r <= `MRR_RST_ACC;
            pc_r <= `MRR_RST_PC;
            z_r <= `MRR_RST_FLAG;
            c_r <= `MRR_RST_FLAG;
            gie_r <= `MRR_RST_FLAG;
            run_r <= `MRR_RST_RUN;
            ptr_r <= `MRR_RST_PTR;
            st_r <= ST_RUN;
            ready_r <= 1'b0;
        end else begin
            acc_r <= acc_nxt;
            pc_r <= pc_nxt;
            z_r <= z_nxt;
            c_r <= c_nxt;
            gie_r <= gie_nxt;
            run_r <= run_nxt;
            ptr_r <= ptr_nxt;
            st_r <= st_nxt;
            ready_r <= ready_nxt;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0;
        end else begin
            ack_r <= bus_req && !ack_r;
            dat_r <= (bus_req && !ack_r) ? rd_val : 32'h0;
        end
    end

    // Storage has no reset; the instruction write is last, so it wins
    always_ff @(posedge clk_sys) begin
        if (wr_lo && hit_file)
            file_mem[bus_idx] <= wb_dat_i[7:0];
        if (file_we)
            file_mem[instr_file] <= res; // RL1 RL5 RL9
        if (push)
            stk_mem[ptr_r] <= pc_bus;
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign instr_ready = ready_r;
    assign pc_out = pc_r;
    assign acc_out = acc_r;
    assign irq_enable = gie_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    wire logic solo;
    assign solo = accept && !bus_wr;

    a_copy_to_acc: assert property (@(posedge clk_sys) disable iff (rst) // RL1
        solo && instr_op == OP_COPY && !instr_dest |=> acc_r == $past(src))
        else $error("copy did not reach accumulator");
    a_copy_zero: assert property (@(posedge clk_sys) disable iff (rst) // RL2
        solo && instr_op == OP_COPY |=> z_r == ($past(src) == 8'h00)
        && file_mem[$past(instr_file)] == $past(src))
        else $error("copy zero flag wrong");
    a_literal_load: assert property (@(posedge clk_sys) disable iff (rst) // RL3
        solo && instr_op == OP_LOADK |=> acc_r == $past(instr_lit) && $stable(z_r)
        && $stable(c_r))
        else $error("literal load wrong");
    a_irq_return: assert property (@(posedge clk_sys) disable iff (rst) // RL4
        solo && instr_op == OP_RETI |=> gie_r && pc_r == $past(stk_head)
        && $stable(z_r) && $stable(c_r))
        else $error("interrupt return wrong");
    a_store_acc: assert property (@(posedge clk_sys) disable iff (rst) // RL5
        solo && instr_op == OP_STORE |=> file_mem[$past(instr_file)] == $past(acc_r)
        && $stable(z_r) && $stable(c_r))
        else $error("store wrong");
    a_literal_ret: assert property (@(posedge clk_sys) disable iff (rst) // RL6
        solo && instr_op == OP_RETK |=> acc_r == $past(instr_lit)
        && pc_r == $past(stk_head) && $stable(z_r))
        else $error("literal return wrong");
    a_ret_two_cyc: assert property (@(posedge clk_sys) disable iff (rst) // RL7
        accept && instr_op == OP_RETK |=> !instr_ready ##1 (instr_ready == $past(run_nxt)))
        else $error("literal return not two cycles");
    a_rotate_carry: assert property (@(posedge clk_sys) disable iff (rst) // RL8
        solo && instr_op == OP_RLC |=> c_r == $past(src[7]) && $stable(z_r))
        else $error("rotate carry wrong");
    a_rotate_dest: assert property (@(posedge clk_sys) disable iff (rst) // RL9
        solo && instr_op == OP_RLC && !instr_dest
        |=> acc_r == {$past(src[6:0]), $past(c_r)})
        else $error("rotate result wrong");
    a_idle_step: assert property (@(posedge clk_sys) disable iff (rst) // RL10
        solo && instr_op == OP_IDLE |=> pc_r == $past(pc_r) + `MRR_PC_STEP
        && instr_ready == $past(run_nxt) && $stable(acc_r))
        else $error("idle did not step pc");
endmodule

`default_nettype wire

// ---- mrr_fetch_model.sv ----
/*
 Fetch-side model for the execute block: offers one instruction at a time
 and holds it until the block takes it.
 Assumes the bench calls issue and rel from its own sequence on clk_sys.
*/
`default_nettype none

module mrr_fetch_model (
    input wire logic clk_sys,
    input wire logic instr_ready,
    output var logic instr_valid,
    output var mrr_pkg::mrr_op_e instr_op,
    output var logic [6:0] instr_file,
    output var logic instr_dest,
    output var logic [7:0] instr_lit
);
    import mrr_pkg::*;

    initial begin
        instr_valid = 1'b0;
        instr_op = OP_IDLE;
        instr_file = 7'h55;
        instr_dest = 1'b0;
        instr_lit = 8'h5a;
    end

    // Operands stay put until the edge that takes them; waited counts edges
    task automatic issue(input mrr_op_e op, input logic [6:0] f, input logic d,
                         input logic [7:0] k, output int waited);
        waited = 0;
        instr_valid <= 1'b1;
        instr_op <= op;
        instr_file <= f;
        instr_dest <= d;
        instr_lit <= k;
        do begin
            @(posedge clk_sys);
            waited++;
        end while (instr_ready !== 1'b1);
    endtask

    // Released operands flip so a stale value can never pass for a fresh one
    task automatic rel();
        instr_valid <= 1'b0;
        instr_file <= ~instr_file;
        instr_dest <= ~instr_dest;
        instr_lit <= ~instr_lit;
    endtask
endmodule

`default_nettype wire

// ---- move_return_rotate_exec_tb.sv ----
/*
 Self-checking bench for mrr_exec: Wishbone register tasks and a fetch
 model issuing instructions, with expected values worked out here.
 Assumes the header, package, design and fetch model are compiled first.
*/
`default_nettype none
`include "mrr_cfg.svh"

module move_return_rotate_exec_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mrr_pkg::*;

    logic clk_sys, rst, cyc, stb, we, wb_ack_o, instr_valid, instr_dest;
    logic instr_ready, irq_enable;
    logic [9:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, q, wb_dat_o;
    logic [6:0] instr_file;
    logic [7:0] instr_lit, acc_out;
    mrr_op_e instr_op;
    mrr_pc_t pc_out;
    int fail_count, comparisons, n;

    mrr_exec u_dut (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .instr_valid(instr_valid),
        .instr_op(instr_op), .instr_file(instr_file), .instr_dest(instr_dest),
        .instr_lit(instr_lit), .instr_ready(instr_ready), .pc_out(pc_out),
        .acc_out(acc_out), .irq_enable(irq_enable));

    mrr_fetch_model u_fetch (.clk_sys(clk_sys), .instr_ready(instr_ready),
        .instr_valid(instr_valid), .instr_op(instr_op), .instr_file(instr_file),
        .instr_dest(instr_dest), .instr_lit(instr_lit));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'h3;
        // Only the watchdog ends a wait that never sees ack
        do begin
            @(posedge clk_sys);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        check("bus read", q, exp);
    endtask

    task automatic exec(input mrr_op_e op, input logic [6:0] f, input logic d,
                        input logic [7:0] k);
        u_fetch.issue(op, f, d, k, n);
        u_fetch.rel();
        // Results are looked at one edge after the taking edge
        @(posedge clk_sys);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 10'h000;
        sel = 4'h0;
        wdat = 32'h0;
        fail_count = 0;
        comparisons = 0;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        rd_chk(`MRR_OFS_CTRL, 32'h1);
        rd_chk(`MRR_OFS_STATUS, 32'h0);
        wb(1'b1, `MRR_OFS_STATUS, 32'h3);
        exec(OP_LOADK, 7'h00, 1'b0, 8'ha5);
        check("acc", 32'(acc_out), 32'ha5);
        rd_chk(`MRR_OFS_ACC, 32'ha5);
        rd_chk(`MRR_OFS_STATUS, 32'h3);
        exec(OP_STORE, 7'h7f, 1'b0, 8'h00);
        rd_chk(10'h3fc, 32'ha5);
        wb(1'b1, `MRR_OFS_STATUS, 32'h2);
        wb(1'b1, 10'h214, 32'h0);
        exec(OP_COPY, 7'h05, 1'b0, 8'h00);
        check("acc", 32'(acc_out), 32'h0);
        rd_chk(`MRR_OFS_STATUS, 32'h3);
        exec(OP_COPY, 7'h7f, 1'b1, 8'h00);
        check("acc", 32'(acc_out), 32'h0);
        rd_chk(10'h3fc, 32'ha5);
        rd_chk(`MRR_OFS_STATUS, 32'h2);
        // Carry in is 1 here, so bit 0 of the result shows it
        wb(1'b1, 10'h20c, 32'h81);
        exec(OP_RLC, 7'h03, 1'b1, 8'h00);
        rd_chk(10'h20c, 32'h03);
        check("acc", 32'(acc_out), 32'h0);
        rd_chk(`MRR_OFS_STATUS, 32'h2);
        wb(1'b1, `MRR_OFS_STATUS, 32'h1);
        // Bit 7 set with carry clear, so the carry must rise
        wb(1'b1, 10'h210, 32'hc0);
        exec(OP_RLC, 7'h04, 1'b0, 8'h00);
        check("acc", 32'(acc_out), 32'h80);
        rd_chk(`MRR_OFS_STATUS, 32'h3);
        wb(1'b1, `MRR_OFS_PC, 32'h0ffe);
        exec(OP_IDLE, 7'h00, 1'b0, 8'h00);
        check("pc", 32'(pc_out), 32'h0fff);
        wb(1'b1, 10'h014, 32'hff);
        rd_chk(10'h014, 32'h0);
        wb(1'b1, `MRR_OFS_CTRL, 32'h0);
        check("ready", 32'(instr_ready), 32'h0);
        wb(1'b1, `MRR_OFS_CTRL, 32'h1);
        wb(1'b1, `MRR_OFS_STATUS, 32'h0);
        wb(1'b1, `MRR_OFS_STACK, 32'h0abc);
        wb(1'b1, `MRR_OFS_STACK, 32'h1555);
        rd_chk(`MRR_OFS_STACK, 32'h1555);
        u_fetch.issue(OP_RETK, 7'h00, 1'b0, 8'h3c, n);
        // Next instruction is offered at once, so its wait shows the dead cycle
        fork
            u_fetch.issue(OP_IDLE, 7'h00, 1'b0, 8'h00, n);
            begin
                @(posedge clk_sys);
                check("acc", 32'(acc_out), 32'h3c);
                check("pc", 32'(pc_out), 32'h1555);
                check("ready", 32'(instr_ready), 32'h0);
            end
        join
        u_fetch.rel();
        @(posedge clk_sys);
        check("edges", 32'(n), 32'h2);
        check("pc", 32'(pc_out), 32'h1556);
        exec(OP_RETI, 7'h00, 1'b0, 8'h00);
        check("pc", 32'(pc_out), 32'h0abc);
        check("irq", 32'(irq_enable), 32'h1);
        rd_chk(`MRR_OFS_PC, 32'h0abc);
        rd_chk(`MRR_OFS_STATUS, 32'h4);
        end_of_test();
    end

    initial begin
        repeat (5000) @(posedge clk_sys);
        fail_count++;
        end_of_test();
    end
endmodule

`default_nettype wire
